// file: core/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_CNT_W 7
`define WDT_CLR_BIT 7
`define CTL_RSEL_BIT 4
`define CTL_RCSEL_BIT 5
`define CTL_BTCL_BIT 0
`define BIT_W 8
`define PRE_W 10
`define BIT_TOP 8'hff
`define BIT_RC_HALF 8'h80
`define PRE_MIN_DIV 8
`define CTL_RESET 8'h00
`define CMP_RESET 8'h00
`define RST_PULSE_CYC 4'h8
`endif

// file: core/wdt_pkg.sv
package wdt_pkg;
    typedef struct packed {
        logic wr_ctl;
        logic wr_cmp;
        logic [7:0] wdata;
    } cpu_wr_t;
    typedef struct packed {
        logic wdt_irq_flag;
        logic sys_reset;
        logic reset_pin_b;
        logic main_osc_on;
    } wdt_out_t;
    typedef enum logic [1:0] {ST_RUN, ST_RST} rst_state_t;
endpackage

// file: core/watchdog_timer_7bit.sv
`timescale 1ns/1ps
`include "wdt_map.svh"
module watchdog_timer_7bit (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire wdt_pkg::cpu_wr_t cpu_wr,
    input wire logic irq_clear,
    input wire logic [2:0] bit_div_sel,
    input wire logic rc_tick,
    input wire logic stop_mode,
    input wire logic sub_clock_mode,
    output wdt_pkg::wdt_out_t wdt_out,
    output logic [7:0] interval_count_reg,
    output logic [7:0] watchdog_compare_reg,
    output logic [7:0] clock_ctrl_reg,
    output logic halt_others
);
    // =========================================================
    // control registers
    logic [7:0] ctl_ff, nxt_ctl;
    logic [7:0] cmp_ff, nxt_cmp;
    logic wd_rst;
    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_cmp = cmp_ff;
        nxt_ctl[`CTL_BTCL_BIT] = 1'b0;
        nxt_cmp[`WDT_CLR_BIT] = 1'b0;
        if (cpu_wr.wr_ctl) begin
            nxt_ctl = cpu_wr.wdata;
        end
        if (cpu_wr.wr_cmp) begin
            nxt_cmp = cpu_wr.wdata;
        end
        if (wd_rst) begin
            nxt_ctl = `CTL_RESET;
            nxt_cmp = `CMP_RESET;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctl_ff <= `CTL_RESET;
            cmp_ff <= `CMP_RESET;
        end else begin
            ctl_ff <= nxt_ctl;
            cmp_ff <= nxt_cmp;
        end
    end
    wire rsel = ctl_ff[`CTL_RSEL_BIT];
    wire rcsel = ctl_ff[`CTL_RCSEL_BIT];
    // =========================================================
    // basic interval timer
    logic [`PRE_W-1:0] pre_ff, nxt_pre;
    logic [`BIT_W-1:0] bit_ff, nxt_bit;
    logic bit_tick, pre_hit, started_ff, nxt_started;
    // low prescaler bits that must all be one for a step; 1024 wraps to an all-ones mask
    wire [`PRE_W-1:0] pre_mask = (`PRE_W'(`PRE_MIN_DIV) << bit_div_sel) - `PRE_W'(1);
    always_comb begin
        nxt_pre = pre_ff;
        nxt_bit = bit_ff;
        pre_hit = 1'b0;
        bit_tick = 1'b0;
        nxt_started = started_ff;
        if (rcsel) begin
            pre_hit = rc_tick;
        end else if (!stop_mode) begin
            nxt_pre = pre_ff + 1'b1;
            // divide by 8 << sel, sel 0..7 gives 8..1024
            pre_hit = ((pre_ff & pre_mask) == pre_mask);
        end
        if (pre_hit) begin
            nxt_bit = bit_ff + 1'b1;
            bit_tick = (bit_ff == `BIT_TOP);
        end
        if (ctl_ff[`CTL_BTCL_BIT]) begin
            nxt_pre = '0;
            // rc source starts half a timer cycle in: that is the 128-tick offset of the time-out
            nxt_bit = rcsel ? `BIT_RC_HALF : '0;
            nxt_started = 1'b1;
        end
        if (wd_rst) begin
            nxt_started = 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pre_ff <= '0;
            bit_ff <= '0;
            started_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            bit_ff <= nxt_bit;
            started_ff <= nxt_started;
        end
    end
    // =========================================================
    // watchdog counter and match
    logic [`WDT_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic irq_ff, nxt_irq, match;
    logic wd_adv;
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_irq = irq_ff;
        // rc source: counter steps every 256 rc ticks via the interval timer
        wd_adv = started_ff & bit_tick & (rcsel | !stop_mode);
        match = wd_adv & (cnt_ff == cmp_ff[`WDT_CNT_W-1:0]);
        if (irq_clear) begin
            nxt_irq = 1'b0;
        end
        if (match && !rsel) begin
            nxt_irq = 1'b1;
        end
        if (match) begin
            nxt_cnt = '0;
        end else if (wd_adv) begin
            nxt_cnt = cnt_ff + 1'b1;
        end
        if (cmp_ff[`WDT_CLR_BIT] || wd_rst) begin
            nxt_cnt = '0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            irq_ff <= nxt_irq;
        end
    end
    // =========================================================
    // reset pulse generator
    wdt_pkg::rst_state_t st_ff, nxt_st;
    logic [3:0] rcnt_ff, nxt_rcnt;
    logic osc_ff, nxt_osc;
    always_comb begin
        nxt_st = st_ff;
        nxt_rcnt = rcnt_ff;
        nxt_osc = osc_ff & sub_clock_mode;
        unique case (st_ff)
            wdt_pkg::ST_RUN: begin
                if (match && rsel) begin
                    nxt_st = wdt_pkg::ST_RST;
                    nxt_rcnt = `RST_PULSE_CYC;
                    nxt_osc = sub_clock_mode;
                end
            end
            wdt_pkg::ST_RST: begin
                nxt_rcnt = rcnt_ff - 1'b1;
                if (rcnt_ff == 4'h1) begin
                    nxt_st = wdt_pkg::ST_RUN;
                end
            end
            default: nxt_st = wdt_pkg::ST_RUN;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_ff <= wdt_pkg::ST_RUN;
            rcnt_ff <= '0;
            osc_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            rcnt_ff <= nxt_rcnt;
            osc_ff <= nxt_osc;
        end
    end
    assign wd_rst = (st_ff == wdt_pkg::ST_RST);
    always_comb begin
        wdt_out.wdt_irq_flag = irq_ff;
        wdt_out.sys_reset = wd_rst;
        wdt_out.reset_pin_b = !wd_rst;
        wdt_out.main_osc_on = osc_ff | !sub_clock_mode;
    end
    assign interval_count_reg = bit_ff;
    assign watchdog_compare_reg = cmp_ff;
    assign clock_ctrl_reg = ctl_ff;
    assign halt_others = stop_mode & rcsel;
    // =========================================================
    // checks
    // a new compare write in the clear cycle may legally set the clear bit again
    cl_self_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmp_ff[`WDT_CLR_BIT] && !cpu_wr.wr_cmp |=> !cmp_ff[`WDT_CLR_BIT] && cnt_ff == '0)
        else $error("clear bit did not self clear");

    match_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        match && !rsel && !wd_rst |=> irq_ff)
        else $error("interrupt flag not set on match");

    match_rst_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        match && rsel && st_ff == wdt_pkg::ST_RUN |=> !wdt_out.reset_pin_b [*8])
        else $error("reset pulse too short");

    sel_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wd_rst |=> !rsel)
        else $error("reset select survived reset");

    stop_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stop_mode && !rcsel && !cmp_ff[`WDT_CLR_BIT] && !wd_rst |=> $stable(cnt_ff))
        else $error("counter moved in stop");

    no_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !started_ff |-> !wd_adv)
        else $error("counter ran before interval timer clear");

    halt_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stop_mode && rcsel |-> halt_others)
        else $error("halt not raised");

    cmp_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !cpu_wr.wr_cmp && !wd_rst |=> cmp_ff[6:0] == $past(cmp_ff[6:0]))
        else $error("compare value changed without write");

    // =========================================================
    // sequences for the multi-step behaviours
    // entry into the watchdog reset from a running block
    sequence rst_enter_s;
        match && rsel && st_ff == wdt_pkg::ST_RUN;
    endsequence

    // exactly eight reset cycles, then the block runs again
    sequence rst_pulse_s;
        wdt_out.sys_reset [*8] ##1 !wdt_out.sys_reset;
    endsequence

    // a software clear of the counter that no new write overrides
    sequence cnt_clear_s;
        cmp_ff[`WDT_CLR_BIT] && !cpu_wr.wr_cmp;
    endsequence

    rst_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rst_enter_s |=> rst_pulse_s)
        else $error("reset pulse length wrong");

    osc_on_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rst_enter_s ##0 sub_clock_mode |=> wdt_out.main_osc_on)
        else $error("main oscillator not restarted");

    clr_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cnt_clear_s |=> cnt_ff == '0)
        else $error("counter not cleared");

    irq_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        irq_clear && !(match && !rsel) |=> !wdt_out.wdt_irq_flag)
        else $error("interrupt flag not cleared");

    irq_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        irq_ff && !irq_clear |=> irq_ff)
        else $error("interrupt flag dropped");

    irq_rsel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        match && rsel && !irq_ff |=> !irq_ff)
        else $error("interrupt flag set in reset mode");

    cnt_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wd_adv && !match && !cmp_ff[`WDT_CLR_BIT] && !wd_rst
        |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("counter did not step");

    cnt_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        match && !cmp_ff[`WDT_CLR_BIT] && !wd_rst |=> cnt_ff == '0)
        else $error("counter did not restart after match");

    cnt_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !wd_adv && !cmp_ff[`WDT_CLR_BIT] && !wd_rst |=> $stable(cnt_ff))
        else $error("counter moved without a step");

    btcl_self_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ctl_ff[`CTL_BTCL_BIT] && !cpu_wr.wr_ctl && !wd_rst
        |=> !ctl_ff[`CTL_BTCL_BIT] && started_ff)
        else $error("interval timer clear did not start the counter");

    rc_half_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ctl_ff[`CTL_BTCL_BIT] && rcsel |=> bit_ff == `BIT_RC_HALF)
        else $error("rc start offset wrong");

    bit_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pre_hit && !ctl_ff[`CTL_BTCL_BIT] |=> interval_count_reg == $past(bit_ff) + 1'b1)
        else $error("interval timer did not step");

    rc_run_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rcsel && rc_tick && !ctl_ff[`CTL_BTCL_BIT] |=> bit_ff == $past(bit_ff) + 1'b1)
        else $error("rc tick lost");

    stop_pre_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stop_mode && !rcsel && !ctl_ff[`CTL_BTCL_BIT] |=> $stable(bit_ff))
        else $error("interval timer moved in stop");

    pin_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff == wdt_pkg::ST_RUN |-> wdt_out.reset_pin_b)
        else $error("reset pin low outside reset");

    ctl_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cpu_wr.wr_ctl && !wd_rst |=> clock_ctrl_reg[7:1] == $past(cpu_wr.wdata[7:1]))
        else $error("control write lost");
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, rst_b, irq_clear, rc_tick, stop_mode, sub_clock_mode, rc_run;
    logic [2:0] bit_div_sel;
    wdt_pkg::cpu_wr_t cpu_wr;
    wdt_pkg::wdt_out_t wdt_out;
    logic [7:0] interval_count_reg, watchdog_compare_reg, clock_ctrl_reg;
    logic halt_others;
    int err_total = 0;
    int checks = 0;
    int cyc_cnt = 0;
    int n;
    watchdog_timer_7bit dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cpu_wr(cpu_wr),
        .irq_clear(irq_clear), .bit_div_sel(bit_div_sel), .rc_tick(rc_tick),
        .stop_mode(stop_mode), .sub_clock_mode(sub_clock_mode), .wdt_out(wdt_out),
        .interval_count_reg(interval_count_reg), .watchdog_compare_reg(watchdog_compare_reg),
        .clock_ctrl_reg(clock_ctrl_reg), .halt_others(halt_others));
    initial begin
        clk_sys = 0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ==========================================
    // rc oscillator stand-in and hang guard
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        rc_tick <= rc_run && (cyc_cnt[1:0] == 2'h0);
        if (cyc_cnt == 80000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic is_ctl, input logic [7:0] d);
        @(posedge clk_sys);
        cpu_wr <= '{wr_ctl: is_ctl, wr_cmp: !is_ctl, wdata: d};
        @(posedge clk_sys);
        cpu_wr <= '{wr_ctl: 1'b0, wr_cmp: 1'b0, wdata: 8'h00};
        #1;
    endtask
    task automatic clr_irq();
        @(posedge clk_sys);
        irq_clear <= 1'b1;
        @(posedge clk_sys);
        irq_clear <= 1'b0;
    endtask
    // sel 1 waits for the reset pulse, sel 0 for the interrupt flag
    task automatic wait_hi(input logic sel, input int lim, output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            #1;
            c++;
        end while ((sel ? wdt_out.sys_reset : wdt_out.wdt_irq_flag) !== 1'b1 && c < lim);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // test sequence
    initial begin
        rst_b = 0;
        irq_clear = 0;
        rc_run = 0;
        rc_tick = 0;
        stop_mode = 0;
        sub_clock_mode = 0;
        bit_div_sel = 3'h0;
        cpu_wr = '0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        check("ctl_reset", clock_ctrl_reg, 8'h00);
        check("pin_idle", {7'h00, wdt_out.reset_pin_b}, 8'h01);
        wr(1'b0, 8'h81);
        check("cmp_clear_bit", watchdog_compare_reg, 8'h81);
        @(posedge clk_sys);
        #1;
        check("cmp_self_clear", watchdog_compare_reg, 8'h01);
        wr(1'b1, 8'h01);
        wait_hi(1'b0, 7000, n);
        check("irq_first", {7'h00, wdt_out.wdt_irq_flag}, 8'h01);
        clr_irq();
        wait_hi(1'b0, 5000, n);
        check("irq_period", {7'h00, n + 2 >= 4094 && n + 2 <= 4098}, 8'h01);
        check("no_reset", {7'h00, wdt_out.sys_reset}, 8'h00);
        $display("test interval timer done");
        clr_irq();
        sub_clock_mode <= 1'b1;
        wr(1'b0, 8'h80);
        check("cmp_zero", watchdog_compare_reg, 8'h80);
        wr(1'b1, 8'h11);
        check("osc_off", {7'h00, wdt_out.main_osc_on}, 8'h00);
        wait_hi(1'b1, 5000, n);
        check("pin_low", {7'h00, wdt_out.reset_pin_b}, 8'h00);
        check("osc_on", {7'h00, wdt_out.main_osc_on}, 8'h01);
        check("irq_none", {7'h00, wdt_out.wdt_irq_flag}, 8'h00);
        n = 0;
        while (wdt_out.sys_reset === 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("reset_len", 8'(n), 8'h08);
        check("rsel_cleared", clock_ctrl_reg, 8'h00);
        $display("test watchdog reset done");
        @(posedge clk_sys);
        sub_clock_mode <= 1'b0;
        rc_run <= 1'b1;
        clr_irq();
        wr(1'b0, 8'h81);
        wr(1'b1, 8'h21);
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        @(posedge clk_sys);
        #1;
        check("halt_rc_stop", {7'h00, halt_others}, 8'h01);
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        wait_hi(1'b0, 2400, n);
        check("rc_irq", {7'h00, n >= 900 && n <= 2300}, 8'h01);
        $display("test rc source done");
        // divide by 16, compare 2: three interval-timer periods of 4096 cycles
        clr_irq();
        wr(1'b1, 8'h00);
        @(posedge clk_sys);
        bit_div_sel <= 3'h1;
        wr(1'b1, 8'h01);
        wr(1'b0, 8'h82);
        wait_hi(1'b0, 13000, n);
        check("div16_period", {7'h00, n >= 12280 && n <= 12295}, 8'h01);
        clr_irq();
        repeat (3) begin
            repeat (5000) @(posedge clk_sys);
            wr(1'b0, 8'h82);
        end
        check("fed_no_irq", {7'h00, wdt_out.wdt_irq_flag}, 8'h00);
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        @(posedge clk_sys);
        #1;
        n = interval_count_reg;
        repeat (1000) @(posedge clk_sys);
        #1;
        check("stop_freeze", interval_count_reg, 8'(n));
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        wait_hi(1'b0, 14000, n);
        check("stop_resume", {7'h00, wdt_out.wdt_irq_flag}, 8'h01);
        $display("test prescaled source and stop done");
        complete_run();
    end
endmodule
